/* hdl/csx_pkg.sv */
// Constants shared by the section extension decoder and its record FIFO.
// Assumes a byte stream already split per extension by the framer upstream.
package csx_pkg;
  localparam logic [6:0] EXT_PUNCT = 7'h14;
  localparam logic [6:0] EXT_GSIZE = 7'h15;
  localparam logic [6:0] EXT_FBREQ = 7'h16;
  localparam logic [6:0] EXT_MODCMP = 7'h17;
  localparam logic [3:0] SECT_CHAN = 4'h6;
  localparam logic [3:0] SECT_DL = 4'h1;
  localparam logic [3:0] SECT_PRACH = 4'h3;
  localparam logic [3:0] SECT_UE = 4'h5;
  localparam logic [7:0] GSIZE_MIN = 8'h02;
  localparam logic [7:0] GSIZE_MAX = 8'hFE;
  localparam logic [3:0] SETS_MAX = 4'hC;
  localparam logic [3:0] PUNCT_REC_IDX = 4'h5;
  localparam logic [3:0] PUNCT_LAST_IDX = 4'h9;
  localparam int REC_W = 32;
  localparam int FIFO_DEPTH = 4;
  // Record kind in the top nibble of each FIFO word
  localparam logic [3:0] REC_PUNCT = 4'h1;
  localparam logic [3:0] REC_GSIZE = 4'h2;
  localparam logic [3:0] REC_FBID = 4'h3;
  localparam logic [3:0] REC_PAT = 4'h4;
  localparam logic [3:0] REC_SET = 4'h5;
  typedef enum logic [3:0] {
    S_TYPE = 4'h0,
    S_LEN = 4'h1,
    S_P20_CNT = 4'h3,
    S_P20_FLD = 4'h2,
    S_P23_HDR = 4'h6,
    S_P23_PAT = 4'h7,
    S_P23_SET = 4'h5,
    S_GS = 4'h4,
    S_ACK = 4'hC,
    S_PAD = 4'hD
  } csx_state_t;
endpackage : csx_pkg

/* hdl/csx_fifo.sv */
// Small synchronous FIFO for decoded records.
// Assumes one clock, synchronous reset and a clock enable that freezes it.
module csx_fifo import csx_pkg::*; #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty straight from the occupancy count
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = ce && inValid && inReady;
  assign pop = ce && outValid && outReady;

  // Storage, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers wrap at a power-of-two depth
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + AW'(1);
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + AW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + (AW+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end
endmodule : csx_fifo

/* hdl/csx_decoder.sv */
// Control-plane section extension decoder: puncturing, channel-info group size,
// feedback request and multi-pattern modulation compression.
// Assumes bytes arrive per extension, first byte carrying the type, inLast on
// the final byte (padding included); section fields are stable meanwhile.
module csx_decoder import csx_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] inData,
  input wire logic inValid,
  input wire logic inLast,
  output logic inReady,
  input wire logic sectionStart,
  input wire logic [3:0] sectionType,
  input wire logic [9:0] firstPrb,
  input wire logic [7:0] prbCount,
  input wire logic [9:0] maxPrbLimit,
  input wire logic [7:0] mgmtChanGroupSize,
  input wire logic mgmtGroupValid,
  input wire logic ciValid,
  input wire logic [7:0] ciIndex,
  output logic [9:0] ciStart,
  output logic [7:0] ciLen,
  output logic ciOutValid,
  output logic [7:0] ciGroupCount,
  output logic [7:0] activeGroupSize,
  input wire logic [9:0] allocOrd,
  input wire logic [3:0] symIdx,
  output logic patternHit,
  output logic [15:0] positiveFeedbackId,
  output logic [15:0] negativeFeedbackId,
  output logic formatErr,
  output logic [31:0] recData,
  output logic recValid,
  input wire logic recReady
);
  csx_state_t st_r, stNxt;
  logic [3:0] idx_r, idxNxt;
  logic [6:0] extType_r;
  logic lenTwo_r;
  logic [7:0] patLeft_r, patLeftNxt;
  logic [3:0] setLeft_r, setLeftNxt;
  logic [23:0] hold_r;
  logic take;
  logic wrValid;
  logic [31:0] wrData;
  logic fifoReady;
  logic errNxt;
  logic [7:0] extGs_r;
  logic extGsValid_r;
  logic [13:0] patSym_r;
  logic [3:0] patPrb_r;
  logic mcTypeOk;

  // Back-pressure: no byte is taken unless a record could be stored
  assign inReady = fifoReady;
  assign take = ce && inValid && fifoReady;
  assign mcTypeOk = (sectionType == SECT_DL) || (sectionType == SECT_PRACH) || (sectionType == SECT_UE);

  // Parser decisions and record formation
  always_comb begin
    stNxt = st_r;
    idxNxt = idx_r + 4'h1;
    patLeftNxt = patLeft_r;
    setLeftNxt = setLeft_r;
    wrValid = 1'b0;
    wrData = 32'h0000_0000;
    errNxt = 1'b0;
    case (st_r)
      S_TYPE: begin
        stNxt = S_LEN;
        idxNxt = 4'h0;
      end
      S_LEN: begin
        // One length byte for the one-word extensions, two otherwise
        if (idx_r == 4'h1 || !lenTwo_r) begin
          idxNxt = 4'h0;
          case (extType_r)
            EXT_PUNCT: stNxt = S_P20_CNT;
            EXT_GSIZE: stNxt = S_GS;
            EXT_FBREQ: stNxt = S_ACK;
            EXT_MODCMP: stNxt = S_P23_HDR;
            default: stNxt = S_PAD;
          endcase
        end
      end
      S_P20_CNT: begin
        idxNxt = 4'h0;
        patLeftNxt = inData;
        stNxt = (inData == 8'h00) ? S_PAD : S_P20_FLD;
      end
      S_P20_FLD: begin
        if (idx_r == PUNCT_REC_IDX) begin
          // Step bit cleared when the group bitmap takes over
          wrValid = 1'b1;
          wrData = {REC_PUNCT, hold_r[15:8], hold_r[7:0], inData[7:4],
            inData[3] & ~inData[0], inData[0], 6'h00};
        end
        // Without the group bitmap the pattern ends here, else four more bytes
        if ((idx_r == PUNCT_REC_IDX && !inData[0]) || idx_r == PUNCT_LAST_IDX) begin
          idxNxt = 4'h0;
          patLeftNxt = patLeft_r - 8'h01;
          stNxt = (patLeft_r == 8'h01) ? S_PAD : S_P20_FLD;
        end
      end
      S_GS: begin
        if (idx_r == 4'h1) begin
          stNxt = S_PAD;
          if (sectionType == SECT_CHAN && hold_r[7:0] >= GSIZE_MIN && hold_r[7:0] <= GSIZE_MAX) begin
            wrValid = 1'b1;
            wrData = {REC_GSIZE, 20'h00000, hold_r[7:0]};
          end else begin
            errNxt = 1'b1;
          end
        end
      end
      S_ACK: begin
        if (idx_r == 4'h1) begin
          stNxt = S_PAD;
          wrValid = 1'b1;
          wrData = {REC_FBID, 12'h000, hold_r[7:0], inData};
        end
      end
      S_P23_HDR: begin
        if (idx_r == 4'h0) begin
          patLeftNxt = {4'h0, inData[7:4]};
          if (!mcTypeOk || inData[7:4] == 4'h0) begin
            errNxt = 1'b1;
            stNxt = S_PAD;
          end
        end else begin
          idxNxt = 4'h0;
          stNxt = S_P23_PAT;
        end
      end
      S_P23_PAT: begin
        if (idx_r == 4'h3) begin
          idxNxt = 4'h0;
          setLeftNxt = hold_r[7:4];
          if (hold_r[7:4] == 4'h0 || hold_r[7:4] > SETS_MAX) begin
            errNxt = 1'b1;
            stNxt = S_PAD;
          end else begin
            wrValid = 1'b1;
            wrData = {REC_PAT, hold_r[21:16], hold_r[15:8], hold_r[3:0], hold_r[7:4], 6'h00};
            stNxt = S_P23_SET;
          end
        end
      end
      S_P23_SET: begin
        if (idx_r == 4'h3) begin
          idxNxt = 4'h0;
          wrValid = 1'b1;
          wrData = {REC_SET, hold_r[19:16], hold_r[15:8], hold_r[7], hold_r[6:0], inData};
          setLeftNxt = setLeft_r - 4'h1;
          if (setLeft_r == 4'h1) begin
            patLeftNxt = patLeft_r - 8'h01;
            stNxt = (patLeft_r == 8'h01) ? S_PAD : S_P23_PAT;
          end
        end
      end
      S_PAD: idxNxt = idx_r;
      default: stNxt = S_TYPE;
    endcase
    // The framer's last byte always closes the extension
    if (inLast) begin
      stNxt = S_TYPE;
    end
  end

  // Parser state and byte index
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= S_TYPE;
      idx_r <= 4'h0;
      patLeft_r <= 8'h00;
      setLeft_r <= 4'h0;
    end else if (take) begin
      st_r <= stNxt;
      idx_r <= idxNxt;
      patLeft_r <= patLeftNxt;
      setLeft_r <= setLeftNxt;
    end
  end

  // Header capture and a three-byte history, so fields split over bytes join up
  always_ff @(posedge core_clk) begin
    if (srst) begin
      extType_r <= 7'h00;
      lenTwo_r <= 1'b0;
      hold_r <= 24'h000000;
    end else if (take) begin
      hold_r <= {hold_r[15:0], inData};
      if (st_r == S_TYPE) begin
        extType_r <= inData[6:0];
        lenTwo_r <= (inData[6:0] != EXT_GSIZE) && (inData[6:0] != EXT_FBREQ);
      end
    end
  end

  // Feedback identifiers echo the request; both carry it, the outcome picks
  always_ff @(posedge core_clk) begin
    if (srst) begin
      positiveFeedbackId <= 16'h0000;
      negativeFeedbackId <= 16'h0000;
      formatErr <= 1'b0;
    end else if (ce) begin
      formatErr <= take && errNxt;
      if (take && st_r == S_ACK && idx_r == 4'h1) begin
        positiveFeedbackId <= {hold_r[7:0], inData};
        negativeFeedbackId <= {hold_r[7:0], inData};
      end
    end
  end

  // Group size from the message lasts for the current section only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      extGs_r <= 8'h00;
      extGsValid_r <= 1'b0;
    end else if (ce) begin
      if (take && wrValid && wrData[31:28] == REC_GSIZE) begin
        extGs_r <= wrData[7:0];
        extGsValid_r <= 1'b1;
      end else if (sectionStart) begin
        extGsValid_r <= 1'b0;
      end
    end
  end

  assign activeGroupSize = extGsValid_r ? extGs_r : mgmtChanGroupSize;
  // Sized: the PRB count is a group count and sets the message length
  assign ciGroupCount = prbCount;

  // Channel-info placement, clipped at the PRB limit; far groups drop to zero length
  // Wide enough that index times size never wraps before the limit compare
  logic [17:0] startW;
  logic [17:0] room;
  assign startW = 18'({8'h00, firstPrb}) + 18'(ciIndex) * 18'(activeGroupSize);
  assign room = 18'(maxPrbLimit) - startW;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ciStart <= 10'h000;
      ciLen <= 8'h00;
      ciOutValid <= 1'b0;
    end else if (ce) begin
      ciOutValid <= ciValid && (extGsValid_r || mgmtGroupValid);
      ciStart <= startW[9:0];
      if (startW >= 18'(maxPrbLimit)) begin
        ciLen <= 8'h00;
      end else if (room < 18'(activeGroupSize)) begin
        ciLen <= room[7:0];
      end else begin
        ciLen <= activeGroupSize;
      end
    end
  end

  // Latest symbol/PRB pattern; the PRB bit cycles every four allocated PRBs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      patSym_r <= 14'h0000;
      patPrb_r <= 4'h0;
      patternHit <= 1'b0;
    end else if (ce) begin
      if (take && wrValid && wrData[31:28] == REC_PAT) begin
        patSym_r <= wrData[27:14];
        patPrb_r <= wrData[13:10];
      end
      // Ordinal counts allocated PRBs only, so gaps are skipped upstream
      patternHit <= patPrb_r[allocOrd[1:0]] && (symIdx < 4'hE) && patSym_r[symIdx];
    end
  end

  csx_fifo #(
    .WIDTH(REC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .inValid(take && wrValid),
    .inReady(fifoReady),
    .inData(wrData),
    .outValid(recValid),
    .outReady(recReady),
    .outData(recData)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_punct_step: assert property (take && wrValid && wrData[31:28] == REC_PUNCT && wrData[6] |-> !wrData[7])
    else $error("step bit kept with group bitmap");
  a_rbg_skip: assert property (take && st_r == S_P20_FLD && idx_r == PUNCT_REC_IDX && !inData[0] && !inLast
    && patLeft_r > 8'h01 |=> idx_r == 4'h0)
    else $error("absent group bitmap not skipped");
  a_gsize_range: assert property ($rose(extGsValid_r) |-> extGs_r >= GSIZE_MIN && extGs_r <= GSIZE_MAX)
    else $error("group size out of range accepted");
  a_gsize_type: assert property (take && st_r == S_GS && idx_r == 4'h1 && sectionType != SECT_CHAN |=> formatErr)
    else $error("group size outside type 6 not flagged");
  a_gs_override: assert property (extGsValid_r |-> activeGroupSize == extGs_r)
    else $error("managed size used over message size");
  a_ci_limit: assert property (ciOutValid && ciLen != 8'h00 |-> 11'(ciStart) + 11'(ciLen) <= 11'(maxPrbLimit))
    else $error("channel info beyond PRB limit");
  a_fb_echo: assert property (take && st_r == S_ACK && idx_r == 4'h1 |=>
    positiveFeedbackId == {$past(hold_r[7:0]), $past(inData)} && negativeFeedbackId == positiveFeedbackId)
    else $error("feedback id not echoed");
  a_mc_type: assert property (take && st_r == S_P23_HDR && idx_r == 4'h0 && !mcTypeOk && !inLast |=> st_r == S_PAD)
    else $error("modulation extension taken in wrong type");
  a_set_count: assert property (take && wrValid && wrData[31:28] == REC_PAT |->
    wrData[9:6] != 4'h0 && wrData[9:6] <= SETS_MAX)
    else $error("parameter set count out of range");
  a_no_drop: assert property (take && wrValid && !recValid |=> recValid)
    else $error("record lost on empty FIFO");

  c_punct: cover property (take && wrValid && wrData[31:28] == REC_PUNCT && wrData[6]);
  c_gsize: cover property ($rose(extGsValid_r));
  c_fbid: cover property (take && st_r == S_ACK && idx_r == 4'h1);
  c_set_two: cover property (take && wrValid && wrData[31:28] == REC_SET && setLeft_r == 4'h1 && patLeft_r == 8'h02);
endmodule : csx_decoder

/* dv/csx_du_model.sv */
// Partner model: the distributed unit streaming extension bytes to the decoder.
// Assumes the bench queues whole extensions; each byte is held until inReady.
module csx_du_model (
  input wire logic core_clk,
  input wire logic ce,
  input wire logic inReady,
  output logic [7:0] inData,
  output logic inValid,
  output logic inLast,
  output logic idle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] pend[$];

  // Bench loads reserved fields as zero and ids unique per slot
  task automatic push(input logic [7:0] b, input logic l);
    pend.push_back({l, b});
  endtask : push

  // Byte leaves on the edge that sees valid and ready; next one 1 ns later
  initial begin
    inData = 8'h5A;
    inValid = 1'b0;
    inLast = 1'b0;
    idle = 1'b1;
    forever begin
      @(posedge core_clk);
      // A byte only leaves when the decoder really took it, clock enable included
      if (inValid && inReady === 1'b1 && ce === 1'b1) begin
        void'(pend.pop_front());
      end
      #1;
      if (pend.size() > 0) begin
        {inLast, inData} = pend[0];
        inValid = 1'b1;
      end else begin
        inData = ~inData; // Idle bus toggles, never keeps the last byte
        inValid = 1'b0;
        inLast = 1'b0;
      end
      idle = (pend.size() == 0);
    end
  end
endmodule : csx_du_model

/* dv/csx_decoder_tb.sv */
// Self-checking bench for csx_decoder: feedback, puncturing, group size,
// modulation extensions and the record FIFO.
// Assumes csx_pkg compiled first and csx_du_model as the byte source.
module csx_decoder_tb import csx_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] inData;
  logic inValid, inLast, inReady, idle;
  logic sectionStart = 1'b0;
  logic [3:0] sectionType = 4'h1;
  logic [9:0] firstPrb = 10'h00A;
  logic [7:0] prbCount = 8'h03; // Never zero while sized
  logic [9:0] maxPrbLimit = 10'h014;
  logic [7:0] mgmtChanGroupSize = 8'h08;
  logic mgmtGroupValid = 1'b1;
  logic ciValid = 1'b0;
  logic [7:0] ciIndex = 8'h00;
  logic [9:0] ciStart;
  logic [7:0] ciLen, ciGroupCount, activeGroupSize;
  logic ciOutValid, patternHit, formatErr, recValid;
  logic [9:0] allocOrd = 10'h000;
  logic [3:0] symIdx = 4'h0;
  logic [15:0] positiveFeedbackId, negativeFeedbackId;
  logic [31:0] recData;
  logic recReady = 1'b0;
  int miscompares = 0;
  int checksDone = 0;
  int errSeen = 0;

  // 250 MHz clock
  always #2 core_clk = ~core_clk;

  // Count rejection pulses; a pulse stands one cycle only
  always @(posedge core_clk) begin
    if (formatErr === 1'b1) begin
      errSeen <= errSeen + 1;
    end
  end

  csx_du_model u_csx_du_model (.core_clk(core_clk), .ce(ce), .inReady(inReady), .inData(inData),
    .inValid(inValid), .inLast(inLast), .idle(idle));

  csx_decoder u_csx_decoder (.core_clk(core_clk), .srst(srst), .ce(ce), .inData(inData), .inValid(inValid),
    .inLast(inLast), .inReady(inReady), .sectionStart(sectionStart), .sectionType(sectionType),
    .firstPrb(firstPrb), .prbCount(prbCount), .maxPrbLimit(maxPrbLimit), .mgmtChanGroupSize(mgmtChanGroupSize),
    .mgmtGroupValid(mgmtGroupValid), .ciValid(ciValid), .ciIndex(ciIndex), .ciStart(ciStart), .ciLen(ciLen),
    .ciOutValid(ciOutValid), .ciGroupCount(ciGroupCount), .activeGroupSize(activeGroupSize),
    .allocOrd(allocOrd), .symIdx(symIdx), .patternHit(patternHit), .positiveFeedbackId(positiveFeedbackId),
    .negativeFeedbackId(negativeFeedbackId), .formatErr(formatErr), .recData(recData), .recValid(recValid),
    .recReady(recReady));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (miscompares == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic fail_wait();
    miscompares++;
    $display("Error at %0t ns: wait ran out", $time);
    stop_test();
  endtask : fail_wait

  // Queue one extension, last byte flagged, and wait until it is consumed
  task automatic ext(input logic [7:0] b[$]);
    int n = 0;
    foreach (b[k]) begin
      u_csx_du_model.push(b[k], k == b.size() - 1);
    end
    tick(2);
    while (!idle && n < 200) begin
      tick(1);
      n++;
    end
    if (!idle) fail_wait();
    tick(2);
  endtask : ext

  // Pop one record; an extra cycle keeps recReady from toggling twice at once
  task automatic pop(input logic [31:0] exp, input logic [31:0] msk);
    int n = 0;
    while (recValid !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    if (recValid !== 1'b1) fail_wait();
    check(recData & msk, exp);
    recReady = 1'b1;
    tick(1);
    recReady = 1'b0;
    tick(1);
  endtask : pop

  task automatic ci_q(input logic [7:0] i, input logic [9:0] s, input logic [7:0] l);
    ciValid = 1'b1;
    ciIndex = i;
    tick(1);
    ciValid = 1'b0;
    check({ciOutValid, ciStart, ciLen}, {13'h0, 1'b1, s, l});
    tick(1);
  endtask : ci_q

  task automatic hit_q(input logic [9:0] a, input logic [3:0] s, input logic e);
    allocOrd = a;
    symIdx = s;
    tick(1);
    check(patternHit, e);
  endtask : hit_q

  task automatic t_feedback();
    sectionType = SECT_DL;
    ext('{8'h16, 8'h01, 8'hBE, 8'hEF});
    pop(32'h3000BEEF, 32'hF000FFFF);
    check({positiveFeedbackId, negativeFeedbackId}, 32'hBEEFBEEF);
  endtask : t_feedback

  // Clock enable low: queued bytes must wait and no state may move
  task automatic t_freeze();
    ce = 1'b0;
    u_csx_du_model.push(8'h16, 1'b0);
    u_csx_du_model.push(8'h01, 1'b0);
    u_csx_du_model.push(8'h12, 1'b0);
    u_csx_du_model.push(8'h34, 1'b1);
    tick(6);
    check({idle, recValid, positiveFeedbackId}, {2'b00, 16'hBEEF});
    ce = 1'b1;
    pop(32'h30001234, 32'hF000FFFF);
    check(negativeFeedbackId, 16'h1234);
  endtask : t_freeze

  // Five records into a four-deep FIFO: source must stall, then drain in order
  task automatic t_fifo();
    for (int k = 0; k < 5; k++) begin
      u_csx_du_model.push(8'h16, 1'b0);
      u_csx_du_model.push(8'h01, 1'b0);
      u_csx_du_model.push(8'h40, 1'b0);
      u_csx_du_model.push(8'(k), 1'b1);
    end
    tick(40);
    check({inReady, idle}, 2'b00);
    for (int k = 0; k < 5; k++) begin
      pop({16'h3000, 8'h40, 8'(k)}, 32'hF000FFFF);
    end
  endtask : t_fifo

  // First pattern has no group mask bytes, so the second must start right after it
  task automatic t_punct();
    sectionType = SECT_DL;
    ext('{8'h14, 8'h00, 8'h05, 8'h02, 8'h00, 8'h01, 8'h05, 8'h11, 8'h80, 8'hC8,
      8'h3F, 8'hFF, 8'h00, 8'hA5, 8'hF0, 8'h39, 8'h7F, 8'hFF, 8'hFF, 8'hFF});
    pop(32'h11180C80, 32'hFFFFFFC0);
    pop(32'h1A5F0340, 32'hFFFFFFC0);
  endtask : t_punct

  task automatic t_gsize();
    logic [11:0] bad[4] = '{{SECT_CHAN, 8'h00}, {SECT_CHAN, 8'h01}, {SECT_CHAN, 8'hFF}, {SECT_DL, 8'h06}};
    int e;
    sectionType = SECT_CHAN;
    check(activeGroupSize, 8'h08);
    ext('{8'h15, 8'h01, 8'h04, 8'h00});
    pop(32'h20000004, 32'hF00000FF);
    check({activeGroupSize, ciGroupCount}, 16'h0403);
    ci_q(8'h00, 10'h00A, 8'h04);
    ci_q(8'h01, 10'h00E, 8'h04);
    ci_q(8'h02, 10'h012, 8'h02);
    ci_q(8'h03, 10'h016, 8'h00);
    for (int k = 0; k < 4; k++) begin
      e = errSeen;
      sectionType = bad[k][11:8];
      ext('{8'h15, 8'h01, bad[k][7:0], 8'h00});
      check({errSeen == e + 1, recValid, activeGroupSize}, {2'b10, 8'h04});
    end
    sectionStart = 1'b1;
    tick(1);
    sectionStart = 1'b0;
    check(activeGroupSize, 8'h08);
  endtask : t_gsize

  // One pattern, one set, one instance per carrier, sets cover the mask
  task automatic mod_ext(input logic [3:0] t, input logic [7:0] hdr, input logic [7:0] pat);
    sectionType = t;
    ext('{8'h17, 8'h00, 8'h04, hdr, 8'h00, 8'h2A, 8'h55, pat, 8'h00,
      8'h0A, 8'hAA, 8'h92, 8'h34, 8'h00, 8'h00, 8'h00});
  endtask : mod_ext

  task automatic t_modcmp();
    logic [3:0] sect[3] = '{SECT_DL, SECT_PRACH, SECT_UE};
    logic [19:0] bad[4] = '{{SECT_CHAN, 16'h1016}, {SECT_DL, 16'h0016}, {SECT_DL, 16'h1006}, {SECT_DL, 16'h10D6}};
    int e;
    for (int k = 0; k < 3; k++) begin
      mod_ext(sect[k], 8'h10, 8'h16);
      pop(32'h4A955840, 32'hFFFFFFC0);
      pop(32'h5AAA9234, 32'hFFFFFFFF);
    end
    hit_q(10'h005, 4'h0, 1'b1);
    hit_q(10'h007, 4'h0, 1'b0);
    hit_q(10'h006, 4'h1, 1'b0);
    hit_q(10'h002, 4'hD, 1'b1);
    hit_q(10'h005, 4'hE, 1'b0);
    for (int k = 0; k < 4; k++) begin
      e = errSeen;
      mod_ext(bad[k][19:16], bad[k][15:8], bad[k][7:0]);
      check({errSeen == e + 1, recValid}, 2'b10);
    end
  endtask : t_modcmp

  // Reset for four cycles, then every scenario in turn
  initial begin
    tick(4);
    srst = 1'b0;
    tick(1);
    t_feedback();
    t_freeze();
    t_fifo();
    t_punct();
    t_gsize();
    t_modcmp();
    stop_test();
  end
endmodule : csx_decoder_tb
